// File: rtl/controller_config_and_commands.sv
// configuration register and reset/power-down command registers
// assumes an Avalon-MM master on clk; error inputs are asynchronous pins
`include "ctrl_cfg_defs.svh"
module controller_config_and_commands (
  input  wire logic        clk,              // system clock, 25 MHz
  input  wire logic        rst,              // async reset, active high
  input  wire logic        ce,               // clock enable
  input  wire logic [31:0] address,          // avalon byte address
  input  wire logic        read,             // avalon read
  input  wire logic        write,            // avalon write
  input  wire logic [31:0] writedata,        // avalon write data
  input  wire logic [3:0]  byteenable,       // avalon byte enables
  output logic [31:0]      readdata,         // avalon read data
  output logic             waitrequest,      // avalon wait
  output logic [1:0]       response,         // 00 ok, 10 slave error
  input  wire logic        supervisor,       // cpu in supervisor mode
  input  wire logic        dmaAccess,        // access comes from dma
  input  wire logic        cpuHalted,        // cpu halted
  input  wire logic        cpuErrorMode,     // cpu error mode pin, high active
  input  wire logic        cpuHwFault_n,     // cpu hardware fault, low active
  input  wire logic        cpuCompareErr,    // integer unit compare error
  input  wire logic        floatCompareErr,  // float unit compare error
  input  wire logic        ctrlInternalFault,// controller internal fault
  input  wire logic        watchdogClock,    // watchdog external clock pin
  output logic             systemReset,      // system reset pulse
  output logic             powerDown,        // power-down mode level
  output logic             errorHalt,        // error halt level
  output logic             busTimeoutEnable, // bus timeout on
  output logic             blockProtectSel,  // block protection selected
  output logic             watchdogTick,     // watchdog count tick
  output logic             dmaAllow,         // dma enabled
  output logic             dmaParityCheck,   // dma parity enabled
  output logic             dmaSessionTimeout,// dma session timeout on
  output logic             serialParityOn,   // uart parity enabled
  output logic             serialParityOdd,  // uart odd parity
  output logic             serialTwoStop,    // uart two stop bits
  output logic             serialClockSel,   // uart clock: 1 system, 0 watchdog
  output logic             serialRateNoHalve,// uart rate not halved
  output logic [7:0]       serialScaler,     // uart scaler divide factor
  output logic             irq               // level interrupt
);
  import ctrl_cfg_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [5:0] pinMeta_r;
  logic [5:0] pinSync_r;
  wire  [5:0] pinRaw = {watchdogClock, ctrlInternalFault, floatCompareErr,
                        cpuCompareErr, ~cpuHwFault_n, cpuErrorMode};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta_r <= 6'h00;
      pinSync_r <= 6'h00;
    end else if (ce) begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
    end
  end

  // ****************************************************************
  // bus decode
  // ****************************************************************
  bus_state_t  state_r;
  bus_state_t  state_nxt;
  logic [31:0] cfg_r;
  logic [`IRQ_BITS-1:0] irqStat_r;
  logic [`IRQ_BITS-1:0] irqMask_r;

  wire hitCfg   = (address == `CFG_ADDR_CONFIG);
  wire hitSrst  = (address == `CFG_ADDR_SOFTRST);
  wire hitPdown = (address == `CFG_ADDR_PWRDOWN);
  wire hitStat  = (address == `CFG_ADDR_IRQSTAT);
  wire hitMask  = (address == `CFG_ADDR_IRQMASK);
  wire hitAny   = hitCfg | hitSrst | hitPdown | hitStat | hitMask;
  // sub-word access is refused like any other illegal access
  wire fullWord = (byteenable == 4'hf);
  wire privOk   = supervisor | (dmaAccess & cpuHalted);
  wire idle     = (state_r == BUS_IDLE);
  wire wrTake   = idle & write & hitAny & fullWord & privOk;
  wire rdOk     = hitAny & fullWord;
  wire wrCfg    = wrTake & hitCfg;
  wire wrStat   = wrTake & hitStat;
  wire wrMask   = wrTake & hitMask;
  wire srstCmd  = wrTake & hitSrst & cfg_r[`CFG_SRST_PERMIT];
  wire pdownCmd = wrTake & hitPdown & cfg_r[`CFG_PWRDN_PERMIT];

  wire [31:0] rdMux =
      hitCfg  ? (cfg_r & `CFG_WRITE_MASK) :
      hitStat ? {{(32-`IRQ_BITS){1'b0}}, irqStat_r} :
      hitMask ? {{(32-`IRQ_BITS){1'b0}}, irqMask_r} : 32'h00000000;

  // one wait cycle, answer in the following cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BUS_IDLE: begin
        if (write)
          state_nxt = BUS_WRITE;
        else if (read)
          state_nxt = BUS_READ;
      end
      BUS_WRITE: state_nxt = BUS_IDLE;
      BUS_READ:  state_nxt = BUS_IDLE;
      default:   state_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= BUS_IDLE;
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
      response    <= 2'h0;
    end else if (ce) begin
      state_r     <= state_nxt;
      waitrequest <= ~(idle & (read | write));
      if (idle & read)
        readdata <= rdOk ? rdMux : 32'h00000000;
      if (idle & (read | write))
        response <= (write ? (wrTake | (hitAny & fullWord & ~privOk & 1'b0)) : rdOk)
                    ? 2'h0 : 2'h2;
    end
  end

  // ****************************************************************
  // configuration register
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cfg_r <= `CFG_RESET_VALUE;
    else if (ce && wrCfg)
      cfg_r <= writedata & `CFG_WRITE_MASK;
  end

  // ****************************************************************
  // error handling
  // ****************************************************************
  wire  err_vec_t errIn   = pinSync_r[4:0];
  logic [4:0]     errPrev_r;
  wire  [4:0]     errRise = errIn & ~errPrev_r;
  wire  [4:0]     errMask;
  wire  [4:0]     errAct;
  genvar g;
  for (g = 0; g < 5; g++) begin : g_err
    assign errMask[g] = cfg_r[`CFG_ERR_BASE + 2*g];
    assign errAct[g]  = cfg_r[`CFG_ERR_BASE + 2*g + 1];
  end
  wire [4:0] errLive  = errRise & ~errMask;
  // reset versus halt per source, in bit order 6,8,10,12,14
  wire errReset = |(errLive & errAct);
  wire errHalt  = |(errLive & ~errAct);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      errPrev_r   <= 5'h00;
      systemReset <= 1'b0;
      powerDown   <= 1'b0;
      errorHalt   <= 1'b0;
    end else if (ce) begin
      errPrev_r   <= errIn;
      systemReset <= srstCmd | errReset;
      // power-down and halt hold until the system reset they end
      powerDown   <= ~(srstCmd | errReset) & (powerDown | pdownCmd);
      errorHalt   <= ~(srstCmd | errReset) & (errorHalt | errHalt);
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  wire [`IRQ_BITS-1:0] irqEvt = {errHalt, errReset, pdownCmd, srstCmd};
  wire [`IRQ_BITS-1:0] irqClr = wrStat ? writedata[`IRQ_BITS-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStat_r <= '0;
      irqMask_r <= '0;
      irq       <= 1'b0;
    end else if (ce) begin
      // set wins over a clear in the same cycle
      irqStat_r <= (irqStat_r & ~irqClr) | irqEvt;
      if (wrMask)
        irqMask_r <= writedata[`IRQ_BITS-1:0];
      irq <= |(((irqStat_r & ~irqClr) | irqEvt) & (wrMask ? writedata[`IRQ_BITS-1:0]
                                                          : irqMask_r));
    end
  end

  // ****************************************************************
  // configuration outputs
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busTimeoutEnable  <= 1'b1;
      blockProtectSel   <= 1'b0;
      dmaAllow          <= 1'b1;
      dmaParityCheck    <= 1'b0;
      dmaSessionTimeout <= 1'b1;
      serialParityOn    <= 1'b1;
      serialParityOdd   <= 1'b1;
      serialTwoStop     <= 1'b0;
      serialClockSel    <= 1'b1;
      serialRateNoHalve <= 1'b0;
      serialScaler      <= 8'h01;
    end else if (ce) begin
      busTimeoutEnable  <= cfg_r[`CFG_BUS_TIMEOUT];
      blockProtectSel   <= cfg_r[`CFG_BLOCK_PROT];
      dmaAllow          <= cfg_r[`CFG_DMA_ALLOW];
      dmaParityCheck    <= cfg_r[`CFG_DMA_PARITY];
      dmaSessionTimeout <= cfg_r[`CFG_DMA_TIMEOUT];
      serialParityOn    <= cfg_r[`CFG_SER_PARITY_ON];
      serialParityOdd   <= cfg_r[`CFG_SER_PARITY_ODD];
      serialTwoStop     <= cfg_r[`CFG_SER_TWO_STOP];
      serialClockSel    <= cfg_r[`CFG_SER_CLK_SEL];
      serialRateNoHalve <= cfg_r[`CFG_RATE_NOHALVE];
      serialScaler      <= cfg_r[`CFG_SCALER_LSB +: 8];
    end
  end

  // ****************************************************************
  // watchdog tick
  // ****************************************************************
  watchdog_tick_gen #(
    .DIV(`WD_PRESCALE_DIV)
  ) u_wdtick (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .wdClkSync  (pinSync_r[5]),
    .prescaleOn (cfg_r[`CFG_WD_PRESCALE]),
    .tick       (watchdogTick)
  );
endmodule

// File: inc/ctrl_cfg_defs.svh
// constants for the controller configuration and command registers
// assumes a 32-bit word-aligned register bus; offsets are byte addresses
//
// Summary of operation
// - soft reset write asserts reset when permitted
// - soft reset write ignored when not permitted
// - power-down write enters power-down when permitted
// - power-down write ignored when not permitted
// - bit 3 selects block protection
// - bit 4 selects watchdog divide-by-16 prescaler
// - mask bits 5,7,9,11,13 suppress error sources
// - cpu error mode: bit 6 reset, else halt
// - cpu hardware fault: bit 8 reset, else halt
// - integer compare error: bit 10 reset/halt
// - float compare error: bit 12 reset/halt
// - controller internal fault: bit 14 reset/halt
// - bit 19 one keeps rate, zero halves
// - bits 31-24 hold scaler, reset one
// - bit 23 picks system or watchdog clock
// - writes only from supervisor or halted-cpu dma
`ifndef CTRL_CFG_DEFS_SVH
`define CTRL_CFG_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define CFG_ADDR_CONFIG    32'h01f80000
`define CFG_ADDR_SOFTRST   32'h01f80004
`define CFG_ADDR_PWRDOWN   32'h01f80008
`define CFG_ADDR_IRQSTAT   32'h01f800f0
`define CFG_ADDR_IRQMASK   32'h01f800f4

// ****************************************************************
// configuration fields
// ****************************************************************
`define CFG_PWRDN_PERMIT   0
`define CFG_SRST_PERMIT    1
`define CFG_BUS_TIMEOUT    2
`define CFG_BLOCK_PROT     3
`define CFG_WD_PRESCALE    4
`define CFG_ERR_BASE       5
`define CFG_RESERVED       15
`define CFG_DMA_ALLOW      16
`define CFG_DMA_PARITY     17
`define CFG_DMA_TIMEOUT    18
`define CFG_RATE_NOHALVE   19
`define CFG_SER_PARITY_ON  20
`define CFG_SER_PARITY_ODD 21
`define CFG_SER_TWO_STOP   22
`define CFG_SER_CLK_SEL    23
`define CFG_SCALER_LSB     24
`define CFG_RESET_VALUE    32'h01b50014
`define CFG_WRITE_MASK     32'hffff7fff

// ****************************************************************
// interrupt status bits
// ****************************************************************
`define IRQ_SOFT_RESET     0
`define IRQ_POWER_DOWN     1
`define IRQ_ERR_RESET      2
`define IRQ_ERR_HALT       3
`define IRQ_BITS           4
`define WD_PRESCALE_DIV    16

`endif

// File: inc/ctrl_cfg_pkg.sv
// types shared by the configuration register bank
// assumes the defs header is on the include path
package ctrl_cfg_pkg;
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ  = 3'b100
  } bus_state_t;
  typedef logic [4:0] err_vec_t;
endpackage

// File: rtl/watchdog_tick_gen.sv
// watchdog clock tick generator with optional divide-by-16 prescale
// assumes the watchdog clock arrives already synchronised as a level
`include "ctrl_cfg_defs.svh"
module watchdog_tick_gen #(
  parameter int DIV = `WD_PRESCALE_DIV
) (
  input  wire logic clk,        // system clock
  input  wire logic rst,        // async reset
  input  wire logic ce,         // clock enable
  input  wire logic wdClkSync,  // synchronised watchdog clock level
  input  wire logic prescaleOn, // divide by DIV when high
  output logic      tick        // one pulse per watchdog period, or per DIV periods when prescaleOn is high
);
  logic       wdPrev_r;
  logic [$clog2(DIV)-1:0] div_r;
  wire        wdRise = wdClkSync & ~wdPrev_r;
  wire        divWrap = (div_r == ($clog2(DIV))'(DIV - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdPrev_r <= 1'b0;
      div_r    <= '0;
      tick     <= 1'b0;
    end else if (ce) begin
      wdPrev_r <= wdClkSync;
      if (wdRise)
        div_r <= divWrap ? '0 : div_r + 1'b1;
      tick <= wdRise & (~prescaleOn | divWrap);
    end
  end
endmodule

// File: tb/controller_config_monitor.sv
// checker for the configuration and command register bank
// assumes binding to the bank's top module; one clock domain
module controller_config_monitor (
  input wire logic        clk,               // clock
  input wire logic        rst,               // reset
  input wire logic [31:0] address,           // bus address
  input wire logic        read,              // bus read
  input wire logic        write,             // bus write
  input wire logic [31:0] readdata,          // bus data
  input wire logic        waitrequest,       // bus wait
  input wire logic [1:0]  response,          // bus response
  input wire logic        supervisor,        // privilege
  input wire logic        dmaAccess,         // dma access
  input wire logic        cpuHalted,         // cpu halted
  input wire logic        cpuErrorMode,      // error pin
  input wire logic        cpuHwFault_n,      // error pin
  input wire logic        cpuCompareErr,     // error pin
  input wire logic        floatCompareErr,   // error pin
  input wire logic        ctrlInternalFault, // error pin
  input wire logic        systemReset,       // reset pulse
  input wire logic        powerDown,         // power-down
  input wire logic        blockProtectSel,   // config copy
  input wire logic        serialRateNoHalve, // config copy
  input wire logic        serialClockSel,    // config copy
  input wire logic [7:0]  serialScaler       // config copy
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rdCfg = !waitrequest && read && address == 32'h01f80000 && response == 2'b00;
  wire logic errAny = cpuErrorMode | ~cpuHwFault_n | cpuCompareErr | floatCompareErr
    | ctrlInternalFault;
  AST_CMD_READ_ZERO: assert property (!waitrequest && read && address inside
    {32'h01f80004, 32'h01f80008} |-> readdata == 32'h0) else $error("command read not zero");
  AST_RSVD_ZERO: assert property (rdCfg |-> !readdata[15])
    else $error("reserved bit reads one");
  AST_BLOCK_PROT: assert property (rdCfg |-> blockProtectSel == readdata[3])
    else $error("block protect output differs");
  AST_RATE: assert property (rdCfg |-> serialRateNoHalve == readdata[19])
    else $error("rate output differs");
  AST_SCALER: assert property (rdCfg |-> serialScaler == readdata[31:24])
    else $error("scaler output differs");
  AST_CLK_SEL: assert property (rdCfg |-> serialClockSel == readdata[23])
    else $error("clock select output differs");
  AST_PD_CAUSE: assert property ($rose(powerDown) |-> $past(write)
    && $past(address) == 32'h01f80008) else $error("power-down without command");
  AST_SRST_CAUSE: assert property (systemReset |-> $past(write && address == 32'h01f80004)
    || $past(errAny, 3) || $past(errAny, 4) || $past(errAny, 5)) else $error("stray reset");
  AST_PRIV: assert property (!waitrequest && write && !supervisor
    && !(dmaAccess && cpuHalted) |-> response == 2'b10) else $error("unprivileged write ok");
  cover property (systemReset);
  cover property ($rose(powerDown));
  cover property (rdCfg);
endmodule

bind controller_config_and_commands controller_config_monitor i_controller_config_monitor (
  .clk, .rst, .address, .read, .write, .readdata, .waitrequest, .response, .supervisor,
  .dmaAccess, .cpuHalted, .cpuErrorMode, .cpuHwFault_n, .cpuCompareErr, .floatCompareErr,
  .ctrlInternalFault, .systemReset, .powerDown, .blockProtectSel, .serialRateNoHalve,
  .serialClockSel, .serialScaler);

// File: tb/controller_config_and_commands_bench.sv
// self-checking bench for the configuration and command register bank
// assumes the monitor binds itself; one clock, bus driven at rising edges
module controller_config_and_commands_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  localparam logic [31:0] CFG = 32'h01f80000, SRS = 32'h01f80004, PDN = 32'h01f80008;
  localparam logic [31:0] STA = 32'h01f800f0, MSK = 32'h01f800f4, BAD = 32'h01f8000c;
  typedef struct {logic [31:0] a, d, b, e; logic [1:0] r;} row_t;
  row_t rows[6] = '{'{CFG, 32'hffffffff, CFG, 32'hffff7fff, 2'h0},
    '{CFG, 32'h01000000, CFG, 32'h01000000, 2'h0}, '{CFG, 32'h2a880008, CFG, 32'h2a880008, 2'h0},
    '{BAD, 32'h5, BAD, 32'h0, 2'h2}, '{SRS, 32'h0, SRS, 32'h0, 2'h0},
    '{PDN, 32'h0, PDN, 32'h0, 2'h0}};
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, read = 1'b0, write = 1'b0;
  logic        supervisor = 1'b1, dmaAccess = 1'b0, cpuHalted = 1'b0;
  logic [31:0] address = 32'h0, writedata = 32'h0, rdat;
  logic [3:0]  byteenable = 4'hf;
  logic [4:0]  err = 5'h0;
  logic [2:0]  wdDiv = 3'h0;
  logic [1:0]  rsp;
  wire logic [31:0] readdata;
  wire logic [1:0]  response;
  wire logic        waitrequest, systemReset, powerDown, errorHalt, watchdogTick, irq;
  wire logic        watchdogClock = wdDiv[2];
  int          error_cnt = 0, num_checks = 0, rstCnt = 0, tickCnt = 0, expRst = 0;
  controller_config_and_commands i_controller_config_and_commands (
    .clk, .rst, .ce, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .response, .supervisor, .dmaAccess, .cpuHalted, .cpuErrorMode(err[0]),
    .cpuHwFault_n(~err[1]), .cpuCompareErr(err[2]), .floatCompareErr(err[3]),
    .ctrlInternalFault(err[4]), .watchdogClock, .systemReset, .powerDown, .errorHalt,
    .busTimeoutEnable(), .blockProtectSel(), .watchdogTick, .dmaAllow(), .dmaParityCheck(),
    .dmaSessionTimeout(), .serialParityOn(), .serialParityOdd(), .serialTwoStop(),
    .serialClockSel(), .serialRateNoHalve(), .serialScaler(), .irq);
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    wdDiv <= wdDiv + 3'h1;
    if (systemReset === 1'b1) rstCnt++;
    if (watchdogTick === 1'b1) tickCnt++;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0 && ++n < 50);
    if (n >= 50) error_cnt++;
    rdat = readdata;
    rsp = response;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(input int i);
    err[i] <= 1'b1;
    repeat (6) @(posedge clk);
    err[i] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, CFG, 32'h0);
    chk("cfg reset", 32'h01b50014, rdat);
    $display("test reset done");
    foreach (rows[k]) begin
      bus(1'b1, rows[k].a, rows[k].d);
      chk("write resp", 32'(rows[k].r), 32'(rsp));
      bus(1'b0, rows[k].b, 32'h0);
      chk("read", rows[k].e, rdat);
    end
    chk("ignored reset", 32'h0, 32'(rstCnt));
    chk("ignored pd", 32'h0, 32'(powerDown));
    $display("test rows done");
    bus(1'b1, CFG, 32'h01000003);
    bus(1'b1, PDN, 32'ha5);
    chk("power down", 32'h1, 32'(powerDown));
    bus(1'b1, SRS, 32'h0);
    repeat (2) @(posedge clk);
    expRst = 1;
    chk("soft reset", 32'(expRst), 32'(rstCnt));
    chk("pd cleared", 32'h0, 32'(powerDown));
    $display("test commands done");
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, CFG, 32'h01000002 | (32'h1 << (5 + 2 * i)));
      pulse(i);
      chk("masked", 32'(expRst), 32'(rstCnt));
      chk("masked halt", 32'h0, 32'(errorHalt));
      bus(1'b1, CFG, 32'h01000002 | (32'h1 << (6 + 2 * i)));
      pulse(i);
      expRst++;
      chk("err reset", 32'(expRst), 32'(rstCnt));
      bus(1'b1, CFG, 32'h01000002);
      pulse(i);
      chk("err halt", 32'h1, 32'(errorHalt));
      bus(1'b1, SRS, 32'h0);
      // the clearing soft reset is itself counted as a reset pulse
      expRst++;
      chk("halt cleared", 32'h0, 32'(errorHalt));
      chk("srst counted", 32'(expRst), 32'(rstCnt));
    end
    $display("test errors done");
    // scaler 5 with halving, uart clocked from the watchdog clock (bit 23 zero)
    bus(1'b1, CFG, 32'h05000000);
    supervisor <= 1'b0;
    bus(1'b1, CFG, 32'h02000000);
    chk("no privilege", 32'h2, 32'(rsp));
    supervisor <= 1'b1;
    bus(1'b0, CFG, 32'h0);
    chk("cfg kept", 32'h05000000, rdat);
    supervisor <= 1'b0;
    dmaAccess <= 1'b1;
    cpuHalted <= 1'b1;
    bus(1'b1, CFG, 32'h07000000);
    chk("dma halted write", 32'h0, 32'(rsp));
    supervisor <= 1'b1;
    dmaAccess <= 1'b0;
    cpuHalted <= 1'b0;
    bus(1'b0, CFG, 32'h0);
    chk("dma cfg taken", 32'h07000000, rdat);
    $display("test privilege done");
    bus(1'b1, STA, 32'hf);
    bus(1'b1, MSK, 32'h1);
    chk("irq idle", 32'h0, 32'(irq));
    bus(1'b1, CFG, 32'h01000002);
    bus(1'b1, SRS, 32'h0);
    bus(1'b1, MSK, 32'h1);
    chk("irq set", 32'h1, 32'(irq));
    bus(1'b1, STA, 32'h1);
    chk("irq clear", 32'h0, 32'(irq));
    $display("test interrupt done");
    // watchdog clock rises every 8 cycles, so 32 edges in 256 cycles
    bus(1'b1, CFG, 32'h01000000);
    tickCnt = 0;
    repeat (256) @(posedge clk);
    chk("ticks direct", 32'h1, 32'(tickCnt >= 31 && tickCnt <= 33));
    bus(1'b1, CFG, 32'h01000010);
    tickCnt = 0;
    repeat (256) @(posedge clk);
    chk("ticks divided", 32'h1, 32'(tickCnt >= 1 && tickCnt <= 3));
    $display("test watchdog done");
    conclude;
  end
endmodule
